// file: hdl/afe_config_register_bank.sv
`timescale 1ns/1ps
module afe_config_register_bank
  import afe_config_pkg::*;
(
  // Clock and reset.
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  // Serial port.
  input  wire logic                        i_csb_n,
  input  wire logic                        i_sclk,
  input  wire logic                        i_sdi,
  output logic                             o_sdo,
  output logic                             o_sdo_oe_n,
  // Neighbouring control.
  input  wire logic                        i_lock,
  input  wire logic                        i_soft_reset,
  input  wire logic                        i_start_trigger,
  // Configuration outputs.
  output logic                             o_common_level_output_en,
  output logic [afe_config_pkg::RATE_W-1:0]  o_rate_code,
  output logic [afe_config_pkg::DGAIN_W-1:0] o_digital_gain_code,
  output logic [afe_config_pkg::AGAIN_W-1:0] o_analog_gain_code,
  output logic                             o_gain_bypass,
  output logic                             o_conversion_mode,
  output logic                             o_converting
);
  import afe_config_pkg::*;

  reg_access_if acc ();

  logic [DATA_W-1:0] ref_rate_reg;
  logic [DATA_W-1:0] gain_reg;
  logic [DATA_W-1:0] power_reg;
  logic              armed_reg;
  logic              converting_reg;
  logic              write_ok;

  serial_frame u_frame (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_csb_n    (i_csb_n),
    .i_sclk     (i_sclk),
    .i_sdi      (i_sdi),
    .o_sdo      (o_sdo),
    .o_sdo_oe_n (o_sdo_oe_n),
    .acc        (acc.frame)
  );

  assign write_ok = acc.wr_en && !i_lock;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ref_rate_reg <= RST_REF_RATE;
    end else if (i_soft_reset) begin
      ref_rate_reg <= RST_REF_RATE;
    end else if (write_ok && acc.addr == ADDR_REF_RATE) begin
      ref_rate_reg <= acc.wr_data & MASK_REF_RATE;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gain_reg <= RST_GAIN;
    end else if (i_soft_reset) begin
      gain_reg <= RST_GAIN;
    end else if (write_ok && acc.addr == ADDR_GAIN) begin
      gain_reg <= acc.wr_data & MASK_GAIN;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      power_reg <= RST_POWER;
    end else if (i_soft_reset) begin
      power_reg <= RST_POWER;
    end else if (write_ok && acc.addr == ADDR_POWER) begin
      power_reg <= acc.wr_data & MASK_POWER;
    end
  end

  // Unmapped addresses read as zero.
  always_comb begin
    unique case (acc.addr)
      ADDR_REF_RATE: acc.rd_data = ref_rate_reg;
      ADDR_GAIN:     acc.rd_data = gain_reg;
      ADDR_POWER:    acc.rd_data = power_reg;
      default:       acc.rd_data = '0;
    endcase
  end

  // The lock must be set while conversion mode is already selected, and
  // only then does a trigger start conversion.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed_reg <= 1'b0;
    end else if (!power_reg[PWR_MODE_BIT] || !i_lock || i_soft_reset) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      converting_reg <= 1'b0;
    end else if (!power_reg[PWR_MODE_BIT] || !i_lock || i_soft_reset) begin
      converting_reg <= 1'b0;
    end else if (armed_reg && i_start_trigger) begin
      converting_reg <= 1'b1;
    end
  end

  // One gain setting feeds every channel.
  assign o_common_level_output_en = ref_rate_reg[CML_EN_BIT];
  assign o_rate_code = ref_rate_reg[RATE_LSB +: RATE_W];
  assign o_digital_gain_code = gain_reg[DGAIN_LSB +: DGAIN_W];
  assign o_analog_gain_code = gain_reg[AGAIN_LSB +: AGAIN_W];
  assign o_gain_bypass = gain_reg[BYPASS_BIT];
  assign o_conversion_mode = power_reg[PWR_MODE_BIT];
  assign o_converting = converting_reg;
endmodule

// file: hdl/afe_config_pkg.sv
package afe_config_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 8;
  localparam int          CMD_BITS      = 8;
  localparam int          FRAME_BITS    = 16;
  localparam int          CNT_W         = 5;
  localparam int          RW_BIT        = 7;
  localparam logic        RW_WRITE      = 1'b0;
  localparam logic        RW_READ       = 1'b1;

  localparam logic [6:0]  ADDR_REF_RATE = 7'h02;
  localparam logic [6:0]  ADDR_GAIN     = 7'h03;
  localparam logic [6:0]  ADDR_POWER    = 7'h04;

  localparam logic [7:0]  RST_REF_RATE  = 8'h82;
  localparam logic [7:0]  RST_GAIN      = 8'h52;
  localparam logic [7:0]  RST_POWER     = 8'h00;

  localparam logic [7:0]  MASK_REF_RATE = 8'h83;
  localparam logic [7:0]  MASK_GAIN     = 8'h77;
  localparam logic [7:0]  MASK_POWER    = 8'h01;

  localparam int          CML_EN_BIT    = 7;
  localparam int          RATE_LSB      = 0;
  localparam int          RATE_W        = 2;
  localparam int          DGAIN_LSB     = 4;
  localparam int          DGAIN_W       = 3;
  localparam int          AGAIN_LSB     = 0;
  localparam int          AGAIN_W       = 2;
  localparam int          BYPASS_BIT    = 2;
  localparam int          PWR_MODE_BIT  = 0;

  localparam logic [1:0]  RATE_265      = 2'h0;
  localparam logic [1:0]  RATE_530      = 2'h1;
  localparam logic [1:0]  RATE_1057     = 2'h2;
  localparam logic [1:0]  RATE_1326     = 2'h3;
endpackage

// file: hdl/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
  import afe_config_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;

  modport frame (output wr_en, output addr, output wr_data, input rd_data);
  modport bank  (input wr_en, input addr, input wr_data, output rd_data);
endinterface

// file: hdl/serial_frame.sv
`timescale 1ns/1ps
module serial_frame
  import afe_config_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Serial pins.
  input  wire logic       i_csb_n,
  input  wire logic       i_sclk,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_oe_n,
  // Register side.
  reg_access_if.frame     acc
);
  logic              sclk_reg;
  logic [CNT_W-1:0]  count_reg;
  logic [DATA_W-1:0] shift_in_reg;
  logic [DATA_W-1:0] shift_out_reg;
  logic              is_read_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              rise;
  logic              fall;

  assign rise = !i_csb_n && i_sclk && !sclk_reg;
  assign fall = !i_csb_n && !i_sclk && sclk_reg;
  assign acc.addr = addr_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= i_sclk;
    end
  end

  // Data is captured on rising edges of the serial clock.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_reg    <= '0;
      shift_in_reg <= '0;
    end else if (i_csb_n) begin
      count_reg    <= '0;
    end else if (rise && count_reg < CNT_W'(FRAME_BITS)) begin
      count_reg    <= count_reg + CNT_W'(1);
      shift_in_reg <= {shift_in_reg[DATA_W-2:0], i_sdi};
    end
  end

  // The first byte splits into direction and address.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      is_read_reg <= 1'b0;
      addr_reg    <= '0;
    end else if (rise && count_reg == CNT_W'(CMD_BITS - 1)) begin
      // The direction bit came first, so it now sits one place below the top.
      is_read_reg <= shift_in_reg[RW_BIT-1] == RW_READ;
      addr_reg    <= {shift_in_reg[ADDR_W-2:0], i_sdi};
    end
  end

  // A write completes on the sixteenth rising edge.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc.wr_en   <= 1'b0;
      acc.wr_data <= '0;
    end else begin
      acc.wr_en <= rise && count_reg == CNT_W'(FRAME_BITS - 1) &&
                   !is_read_reg;
      if (rise && count_reg == CNT_W'(FRAME_BITS - 1)) begin
        acc.wr_data <= {shift_in_reg[DATA_W-2:0], i_sdi};
      end
    end
  end

  // Read data leaves on falling edges after the command byte.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shift_out_reg <= '0;
      o_sdo         <= 1'b0;
      o_sdo_oe_n    <= 1'b1;
    end else if (i_csb_n) begin
      o_sdo_oe_n    <= 1'b1;
    end else if (fall && is_read_reg) begin
      if (count_reg == CNT_W'(CMD_BITS)) begin
        shift_out_reg <= {acc.rd_data[DATA_W-2:0], 1'b0};
        o_sdo         <= acc.rd_data[DATA_W-1];
        o_sdo_oe_n    <= 1'b0;
      end else if (count_reg > CNT_W'(CMD_BITS) &&
                   count_reg < CNT_W'(FRAME_BITS)) begin
        shift_out_reg <= {shift_out_reg[DATA_W-2:0], 1'b0};
        o_sdo         <= shift_out_reg[DATA_W-1];
      end else begin
        o_sdo_oe_n    <= 1'b1;
      end
    end
  end
endmodule

// file: verif/afe_config_props.sv
`timescale 1ns/1ps
module afe_config_props
  import afe_config_pkg::*;
(
  // Clock and reset.
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  // Serial port.
  input wire logic       i_csb_n,
  input wire logic       i_sclk,
  input wire logic       o_sdo,
  input wire logic       o_sdo_oe_n,
  // Control and configuration.
  input wire logic       i_lock,
  input wire logic       i_soft_reset,
  input wire logic       i_start_trigger,
  input wire logic       o_common_level_output_en,
  input wire logic [1:0] o_rate_code,
  input wire logic [2:0] o_digital_gain_code,
  input wire logic [1:0] o_analog_gain_code,
  input wire logic       o_gain_bypass,
  input wire logic       o_conversion_mode,
  input wire logic       o_converting
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [9:0] cfg;
  assign cfg = {o_common_level_output_en, o_rate_code, o_digital_gain_code,
                o_analog_gain_code, o_gain_bypass, o_conversion_mode};
  property p_soft_def;
    i_soft_reset |-> ##2 (cfg == 10'h358 && !o_converting);
  endproperty
  a_soft_def: assert property (p_soft_def) else $error("soft default");
  property p_lock_hold;
    i_lock && $past(i_lock) && !i_soft_reset && !$past(i_soft_reset)
      |=> $stable(cfg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked change");
  property p_conv_start;
    $rose(o_converting) |-> $past(i_start_trigger) && $past(i_lock)
      && $past(o_conversion_mode);
  endproperty
  a_conv_start: assert property (p_conv_start) else $error("early start");
  property p_conv_drop;
    !i_lock || !o_conversion_mode |=> !o_converting;
  endproperty
  a_conv_drop: assert property (p_conv_drop) else $error("no stop");
  property p_conv_stay;
    o_converting && i_lock && o_conversion_mode && !i_soft_reset
      |=> o_converting;
  endproperty
  a_conv_stay: assert property (p_conv_stay) else $error("lost run");
  property p_oe_idle;
    i_csb_n |=> o_sdo_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven idle");
  property p_oe_fall;
    $fell(o_sdo_oe_n) |-> $past(i_sclk, 2) && !$past(i_sclk) && !$past(i_csb_n);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("oe not at fall");
  property p_sdo_fall;
    !o_sdo_oe_n && !$past(o_sdo_oe_n) && $changed(o_sdo)
      |-> $past(i_sclk, 2) && !$past(i_sclk);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo not at fall");
  c_conv: cover property ($rose(o_converting));
  c_read: cover property ($fell(o_sdo_oe_n));
  c_soft: cover property (i_soft_reset ##2 cfg == 10'h358);
endmodule

bind afe_config_register_bank afe_config_props i_props (.*);

// file: verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Clock.
  input  wire logic i_clk,
  // Serial pins.
  input  wire logic i_sdo,
  output logic      o_csb_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  initial begin
    o_csb_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // One 16-bit frame; half is the number of cycles each clock level lasts.
  task automatic xfer(input logic rw, input logic [6:0] addr,
                      input logic [7:0] wdat, input int half,
                      output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {rw, addr, wdat};
    rdat = 8'h00;
    @(posedge i_clk) o_csb_n <= 1'b0;
    for (int b = 15; b >= 0; b--) begin
      o_sdi <= frame[b];
      repeat (half) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (half) @(posedge i_clk);
      if (b < 8) rdat[b] = i_sdo;
      o_sclk <= 1'b0;
    end
    repeat (half) @(posedge i_clk);
    o_csb_n <= 1'b1;
    o_sdi <= ~frame[0];
    @(posedge i_clk);
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import afe_config_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_lock = 1'b0;
  logic        i_soft_reset = 1'b0;
  logic        i_start_trigger = 1'b0;
  logic        csb_n, sclk, sdi, sdo, sdo_oe_n, sdo_w;
  wire  [10:0] outs;
  logic [7:0]  rr, gn, pw, rd;
  int          err_total = 0;
  int          n_checks = 0;
  // Command byte, write data, expected read back.
  logic [23:0] rows [20] = '{24'h820082, 24'h830052, 24'h840000, 24'h028383,
    24'h020000, 24'h020101, 24'h02FE82, 24'h037777, 24'h030000, 24'h031111,
    24'h032222, 24'h033B33, 24'h034F47, 24'h03D252, 24'h03E060, 24'h04FE00,
    24'h040101, 24'h040000, 24'h05FF00, 24'hFF0000};
  always #50 i_clk = ~i_clk;
  // A released line shows the inverse of its last bit, so stale data fails.
  assign sdo_w = sdo_oe_n ? ~sdo : sdo;
  spi_host_model i_host (.i_clk(i_clk), .i_sdo(sdo_w), .o_csb_n(csb_n),
    .o_sclk(sclk), .o_sdi(sdi));
  afe_config_register_bank i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_csb_n(csb_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo),
    .o_sdo_oe_n(sdo_oe_n), .i_lock(i_lock), .i_soft_reset(i_soft_reset),
    .i_start_trigger(i_start_trigger), .o_common_level_output_en(outs[10]),
    .o_rate_code(outs[9:8]), .o_digital_gain_code(outs[7:5]),
    .o_analog_gain_code(outs[4:3]), .o_gain_bypass(outs[2]),
    .o_conversion_mode(outs[1]), .o_converting(outs[0]));
  task automatic chk_rd(input logic [7:0] exp);
    n_checks++;
    if (rd !== exp) begin
      err_total++;
      $display("FAIL t=%0t read %h expected %h", $time, rd, exp);
    end
  endtask
  task automatic chk_out(input logic conv);
    logic [10:0] exp;
    exp = {rr[7], rr[1:0], gn[6:4], gn[1:0], gn[2], pw[0], conv};
    @(negedge i_clk);
    n_checks++;
    if (outs !== exp) begin
      err_total++;
      $display("FAIL t=%0t outputs %h expected %h", $time, outs, exp);
    end
    @(posedge i_clk);
  endtask
  task automatic xf(input logic [7:0] cmd, dat, input int half);
    i_host.xfer(cmd[7], cmd[6:0], dat, half, rd);
  endtask
  task automatic trig;
    @(posedge i_clk) i_start_trigger <= 1'b1;
    @(posedge i_clk) i_start_trigger <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic defs;
    rr = RST_REF_RATE;
    gn = RST_GAIN;
    pw = RST_POWER;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    defs();
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    chk_out(1'b0);
    for (int i = 0; i < 20; i++) begin
      if (!rows[i][23]) xf(rows[i][23:16], rows[i][15:8], 2);
      xf({1'b1, rows[i][22:16]}, 8'h00, rows[i][23] ? 5 : 2);
      chk_rd(rows[i][7:0]);
      case (rows[i][22:16])
        7'h02: rr = rows[i][7:0];
        7'h03: gn = rows[i][7:0];
        7'h04: pw = rows[i][7:0];
        default: ;
      endcase
      chk_out(1'b0);
    end
    // Lock before mode leaves the mode write refused.
    i_lock <= 1'b1;
    xf(8'h04, 8'h01, 2);
    trig();
    chk_out(1'b0);
    i_lock <= 1'b0;
    xf(8'h04, 8'h01, 2);
    pw = 8'h01;
    trig();
    chk_out(1'b0);
    i_lock <= 1'b1;
    repeat (2) @(posedge i_clk);
    xf(8'h02, 8'h00, 2);
    xf(8'h82, 8'h00, 2);
    chk_rd(rr);
    trig();
    chk_out(1'b1);
    i_lock <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk_out(1'b0);
    xf(8'h02, 8'h01, 2);
    rr = 8'h01;
    chk_out(1'b0);
    i_soft_reset <= 1'b1;
    @(posedge i_clk) i_soft_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    defs();
    chk_out(1'b0);
    xf(8'h03, 8'h00, 2);
    gn = 8'h00;
    chk_out(1'b0);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    defs();
    chk_out(1'b0);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    end_sim();
  end
endmodule
